//--- usb_td_status_writeback.sv
// Descriptor status write-back logic with APB control and interrupt
// Overview of operation
// R1: Software sets active bit 23; the controller clears it when the transaction completes.
// R2: A STALL handshake from the endpoint clears the active bit.
// R3: Stall bit 22 is set on babble, error counter at zero or a STALL handshake.
// R4: Whenever the stall bit is set the active bit is cleared in the same update.
// R5: A STALL answering a SETUP also reports a CRC/timeout error.
// R6: Buffer error bit 21 is set on receive overrun or transmit underrun.
// R7: After overrun or underrun the written byte count differs from the maximum length.
// R8: On underrun a wrong CRC is sent and the descriptor stays active unless errors hit zero.
// R9: On overrun a timeout is forced on the bus.
// R10: Babble bit 20 is set when babble is detected during the transaction.
// R11: Babble also sets the stall bit 22.
// R12: Babble aborts the current frame at once; execution resumes at the next index.
// R13: NAK bit 19 is set when the device returns a NAK.
// R14: A NAK answering a SETUP also reports a CRC/timeout error.
// R15: An isochronous descriptor is always made inactive after execution.
// R16: CRC/timeout bit 18 is set on no response or a CRC error.
// R17: All flags are written back in one update at the end of each transaction accepted while enabled and idle.
`timescale 1ns/100ps
`default_nettype none
module usb_td_status_writeback
    import utw_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    input  wire logic             txn_done,
    input  wire logic [31:0]      td_word_in,
    input  wire logic             is_setup,
    input  wire logic             stall_hs,
    input  wire logic             nak_hs,
    input  wire logic             babble_det,
    input  wire logic             err_cnt_zero,
    input  wire logic             no_response,
    input  wire logic             crc_err,
    input  wire logic             overrun,
    input  wire logic             underrun,
    input  wire logic [LEN_W-1:0] act_len_in,
    input  wire logic [LEN_W-1:0] max_len_in,
    output logic                  wb_valid,
    output logic [31:0]           wb_data,
    output logic                  frame_abort,
    output logic                  crc_corrupt,
    output logic                  force_timeout,
    output logic                  irq
);
    utw_state_t s_reg;
    utw_state_t s_next;

    logic             accept;
    logic             isochronous_select;
    logic             stall_c;
    logic             crc_timeout_c;
    logic             buffer_error_c;
    logic             keep_active_c;
    logic [LEN_W-1:0] len_c;
    logic [31:0]      word_c;
    logic [EV_W-1:0]  ev_c;
    logic             apb_setup;
    logic             apb_wr;

    assign isochronous_select = td_word_in[BIT_ISO];
    assign accept    = txn_done && s_reg.ctrl_en && (s_reg.st == FSM_IDLE);
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && s_reg.pready && pwrite;

    always_comb begin
        // R3 stall causes
        // R11 babble forces stall
        stall_c = babble_det || err_cnt_zero || stall_hs;
        // R16 timeout or crc
        // R5 R14 setup handshake reports timeout
        crc_timeout_c = no_response || crc_err
                      || (is_setup && (stall_hs || nak_hs));
        buffer_error_c = overrun || underrun;
        // Nak, buffer and crc/timeout outcomes are retried, so they keep
        // the descriptor live; a stall or isochronous always clears it
        // R8 retryable errors stay active
        keep_active_c = !isochronous_select && !stall_c
                      && (nak_hs || buffer_error_c || crc_timeout_c);
        // R7 short count on buffer error
        len_c = act_len_in;
        if (buffer_error_c && (act_len_in == max_len_in)) begin
            len_c = max_len_in - LEN_ONE;
        end
        word_c = td_word_in;
        // R1 R2 R4 R15 active clear
        word_c[BIT_ACTIVE] = keep_active_c;
        word_c[BIT_STALL]  = stall_c;
        // R6 buffer error flag
        word_c[BIT_BUFE]   = buffer_error_c;
        // R10 babble flag
        word_c[BIT_BABBLE] = babble_det;
        // R13 nak flag
        word_c[BIT_NAK]    = nak_hs;
        word_c[BIT_CRCTO]  = crc_timeout_c;
        word_c[LEN_MSB:0]  = len_c;
        ev_c = EV_ZERO;
        ev_c[EV_STALL]  = stall_c;
        ev_c[EV_BUFE]   = buffer_error_c;
        ev_c[EV_BABBLE] = babble_det;
        ev_c[EV_NAK]    = nak_hs;
        ev_c[EV_CRCTO]  = crc_timeout_c;
    end

    always_comb begin
        s_next = s_reg;
        s_next.wb_valid    = 1'b0;
        s_next.frame_abort = 1'b0;
        // Level copies follow the bus side every cycle, not only at done
        // R8 corrupt crc while underrun
        s_next.crc_corrupt   = underrun;
        // R9 force bus timeout
        s_next.force_timeout = overrun;
        unique case (s_reg.st)
            FSM_IDLE: begin
                if (accept) begin
                    // R17 single write-back
                    s_next.wb_valid = 1'b1;
                    s_next.wb_data  = word_c;
                    s_next.last     = word_c;
                    // R12 babble ends frame
                    s_next.frame_abort = babble_det;
                    s_next.st = FSM_WB;
                end
            end
            FSM_WB: begin
                s_next.st = FSM_IDLE;
            end
        endcase
        // Interrupt status, an event beats a same-cycle clear
        if (apb_wr && (paddr == ADDR_ICLR)) begin
            s_next.sts = s_reg.sts & ~pwdata[EV_W-1:0];
        end
        if (accept) begin
            s_next.sts = s_next.sts | ev_c;
        end
        if (apb_wr && (paddr == ADDR_CTRL)) begin
            s_next.ctrl_en = pwdata[CTRL_EN_BIT];
        end
        if (apb_wr && (paddr == ADDR_IEN)) begin
            s_next.ien = pwdata[EV_W-1:0];
        end
        s_next.irq = |(s_next.sts & s_next.ien);
        // Answer one cycle after setup so every output is a flop
        s_next.pready  = apb_setup;
        s_next.pslverr = 1'b0;
        s_next.prdata  = WORD_ZERO;
        if (apb_setup) begin
            unique case (paddr)
                ADDR_CTRL: s_next.prdata[CTRL_EN_BIT] = s_reg.ctrl_en;
                ADDR_STS:  s_next.prdata[EV_W-1:0] = s_reg.sts;
                ADDR_IEN:  s_next.prdata[EV_W-1:0] = s_reg.ien;
                ADDR_ICLR: s_next.prdata = WORD_ZERO;
                ADDR_LAST: s_next.prdata = s_reg.last;
                default:   s_next.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{st: FSM_IDLE, ctrl_en: CTRL_EN_RST, sts: EV_ZERO,
                       ien: EV_ZERO, last: WORD_ZERO, wb_data: WORD_ZERO,
                       prdata: WORD_ZERO, default: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pready        = s_reg.pready;
    assign pslverr       = s_reg.pslverr;
    assign prdata        = s_reg.prdata;
    assign wb_valid      = s_reg.wb_valid;
    assign wb_data       = s_reg.wb_data;
    assign frame_abort   = s_reg.frame_abort;
    assign crc_corrupt   = s_reg.crc_corrupt;
    assign force_timeout = s_reg.force_timeout;
    assign irq           = s_reg.irq;

    logic clean_c;
    assign clean_c = !nak_hs && !buffer_error_c && !crc_timeout_c;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    act_clear_done_a: assert property ( // R1
        accept && clean_c |=> wb_valid && !wb_data[BIT_ACTIVE])
        else $error("active left set after clean completion");
    stall_hs_act_a: assert property ( // R2
        accept && stall_hs |=> !wb_data[BIT_ACTIVE])
        else $error("active left set after stall handshake");
    stall_set_a: assert property ( // R3
        accept |=> wb_data[BIT_STALL] == $past(stall_c))
        else $error("stall flag wrong");
    stall_act_a: assert property ( // R4
        wb_valid && wb_data[BIT_STALL] |-> !wb_data[BIT_ACTIVE])
        else $error("stalled descriptor still active");
    setup_hs_crc_a: assert property ( // R5
        accept && is_setup && (stall_hs || nak_hs)
        |=> wb_data[BIT_CRCTO])
        else $error("setup handshake without timeout flag");
    bufe_set_a: assert property ( // R6
        accept |=> wb_data[BIT_BUFE] == $past(buffer_error_c))
        else $error("buffer error flag wrong");
    len_differs_a: assert property ( // R7
        accept && buffer_error_c
        |=> wb_data[LEN_MSB:0] != $past(max_len_in))
        else $error("length equals maximum after buffer error");
    underrun_keep_a: assert property ( // R8
        accept && underrun && !err_cnt_zero && !stall_hs && !babble_det
        && !isochronous_select |=> wb_data[BIT_ACTIVE])
        else $error("underrun deactivated descriptor");
    // Outcome lines may toggle while reset is held and the copies stay
    // cleared until release, so the followers start from a sampled release
    underrun_crc_a: assert property ( // R8
        presetn && underrun |=> crc_corrupt)
        else $error("no crc corruption on underrun");
    overrun_to_a: assert property ( // R9
        presetn && overrun |=> force_timeout)
        else $error("no forced timeout on overrun");
    babble_set_a: assert property ( // R10
        accept |=> wb_data[BIT_BABBLE] == $past(babble_det))
        else $error("babble flag wrong");
    babble_stall_a: assert property ( // R11
        wb_valid && wb_data[BIT_BABBLE] |-> wb_data[BIT_STALL])
        else $error("babble without stall");
    babble_abort_a: assert property ( // R12
        accept && babble_det |=> frame_abort && wb_valid)
        else $error("frame not aborted on babble");
    nak_set_a: assert property ( // R13
        accept |=> wb_data[BIT_NAK] == $past(nak_hs))
        else $error("nak flag wrong");
    iso_inactive_a: assert property ( // R15
        accept && isochronous_select |=> !wb_data[BIT_ACTIVE])
        else $error("isochronous descriptor left active");
    crc_set_a: assert property ( // R16
        accept && (no_response || crc_err) |=> wb_data[BIT_CRCTO])
        else $error("crc timeout flag missing");
    single_wb_a: assert property ( // R17
        wb_valid |=> !wb_valid)
        else $error("write-back longer than one cycle");
    setup_nak_crc_a: assert property ( // R14
        accept && is_setup && nak_hs |=> wb_data[BIT_CRCTO])
        else $error("setup nak without timeout flag");
    crc_follow_a: assert property ( // R8
        presetn && !underrun |=> !crc_corrupt)
        else $error("crc corruption without underrun");
    timeout_follow_a: assert property ( // R9
        presetn && !overrun |=> !force_timeout)
        else $error("forced timeout without overrun");
    len_keep_a: assert property ( // R7
        accept && !buffer_error_c
        |=> wb_data[LEN_MSB:0] == $past(act_len_in))
        else $error("length altered without buffer error");
    abort_babble_a: assert property ( // R12
        frame_abort |-> wb_valid && wb_data[BIT_BABBLE])
        else $error("frame aborted without babble");
    abort_pulse_a: assert property ( // R12
        frame_abort |=> !frame_abort)
        else $error("frame abort longer than one cycle");
    stall_clear_a: assert property ( // R4
        accept && err_cnt_zero
        |=> wb_data[BIT_STALL] && !wb_data[BIT_ACTIVE])
        else $error("error count zero left descriptor live");
    nak_keep_a: assert property ( // R13
        accept && nak_hs && !stall_c && !isochronous_select
        |=> wb_data[BIT_ACTIVE])
        else $error("nak retry deactivated descriptor");
    crc_clean_a: assert property ( // R16
        accept && !no_response && !crc_err && !is_setup
        |=> !wb_data[BIT_CRCTO])
        else $error("crc timeout flag without cause");
    ctrl_off_a: assert property ( // R17
        txn_done && !s_reg.ctrl_en |=> !wb_valid)
        else $error("transaction taken while disabled");

    // Bookkeeping around the write-back: answer, hold, refusal, status
    wb_answer_a: assert property ( // R17
        accept |=> wb_valid)
        else $error("no write-back after accepted transaction");
    wb_hold_a: assert property ( // R17
        !wb_valid |-> $stable(wb_data))
        else $error("status word changed outside write-back");
    busy_refuse_a: assert property ( // R17
        wb_valid && txn_done |=> !wb_valid)
        else $error("transaction taken during write-back");
    last_copy_a: assert property ( // R17
        wb_valid |-> s_reg.last == wb_data)
        else $error("last word differs from write-back");
    upper_copy_a: assert property ( // R17
        accept |=> wb_data[31:BIT_ISO] == $past(td_word_in[31:BIT_ISO]))
        else $error("descriptor upper bits altered");
    sts_set_a: assert property ( // R17
        accept |=> (s_reg.sts & $past(ev_c)) == $past(ev_c))
        else $error("event lost in status register");
    irq_level_a: assert property ( // R17
        irq == |(s_reg.sts & s_reg.ien))
        else $error("interrupt level disagrees with status");

    clean_cov: cover property (accept && clean_c ##1 wb_valid);
    babble_cov: cover property (accept && babble_det ##1 frame_abort);
    irq_cov: cover property (!irq ##1 irq);
    nak_cov: cover property (accept && nak_hs ##1 wb_data[BIT_ACTIVE]);
    bufe_cov: cover property (accept && underrun
                              ##1 crc_corrupt && wb_data[BIT_ACTIVE]);
endmodule
`default_nettype wire

//--- usb_td_status_writeback_test.sv
// Self-checking bench for the descriptor status write-back block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module usb_td_status_writeback_test import utw_pkg::*;;
    logic             pclk, presetn, psel, penable, pwrite, se;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, wb_data, td, rd;
    logic             pready, pslverr, wb_valid, frame_abort;
    logic             crc_corrupt, force_timeout, irq, done, go;
    logic [8:0]       oc, ln;
    logic [LEN_W-1:0] act, mx;
    int               err_count, n_tests;

    usb_td_status_writeback i_usb_td_status_writeback (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .txn_done(done),
        .td_word_in(td), .is_setup(ln[8]), .stall_hs(ln[7]),
        .nak_hs(ln[6]), .babble_det(ln[5]), .err_cnt_zero(ln[4]),
        .no_response(ln[3]), .crc_err(ln[2]), .overrun(ln[1]),
        .underrun(ln[0]), .act_len_in(act), .max_len_in(mx),
        .wb_valid(wb_valid), .wb_data(wb_data), .frame_abort(frame_abort),
        .crc_corrupt(crc_corrupt), .force_timeout(force_timeout),
        .irq(irq));
    utw_endpoint_model i_utw_endpoint_model (
        .pclk(pclk), .go(go), .oc(oc), .done(done), .lines(ln));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic conclude;
        $display("Tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            err_count++;
            conclude();
        end
        @(posedge pclk);
    endtask

    // One transaction; max length is fixed at 7 (n-1 encoded)
    task automatic txn(input logic [8:0] o, input logic [31:0] t,
                       input logic [LEN_W-1:0] a, input logic [31:0] ew);
        int i;
        oc  <= o;
        td  <= t;
        act <= a;
        go  <= 1'b1;
        @(posedge pclk);
        go  <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            #1;
            if (wb_valid === 1'b1) break;
        end
        if (i == 8) begin
            err_count++;
            conclude();
        end
        `CHK(wb_data, ew)
        `CHK(frame_abort, o[5])
        `CHK(crc_corrupt, o[0])
        `CHK(force_timeout, o[1])
        @(posedge pclk);
    endtask

    task automatic t_stall;
        txn(9'h180, 32'h0080_0000, 11'h005, 32'h0044_0005);
        txn(9'h020, 32'h0080_0000, 11'h005, 32'h0050_0005);
        $display("t_stall done");
    endtask

    task automatic t_nak;
        txn(9'h040, 32'h0080_0000, 11'h005, 32'h0088_0005);
        txn(9'h140, 32'h0080_0000, 11'h005, 32'h008C_0005);
        txn(9'h040, 32'h0280_0000, 11'h005, 32'h0208_0005);
        $display("t_nak done");
    endtask

    task automatic t_buffer;
        txn(9'h001, 32'h0080_0000, 11'h007, 32'h00A0_0006);
        txn(9'h012, 32'h0080_0000, 11'h007, 32'h0060_0006);
        $display("t_buffer done");
    endtask

    task automatic t_timeout;
        txn(9'h008, 32'h0080_0000, 11'h005, 32'h0084_0005);
        txn(9'h004, 32'h0080_0000, 11'h005, 32'h0084_0005);
        txn(9'h000, 32'h0080_0000, 11'h005, 32'h0000_0005);
        $display("t_timeout done");
    endtask

    task automatic t_ctrl;
        int i;
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0001)
        apb(1'b1, ADDR_CTRL, 32'h0);
        oc <= 9'h040;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (i = 0; i < 4; i++) begin
            @(posedge pclk);
            #1;
            `CHK(wb_valid, 1'b0)
        end
        @(posedge pclk);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        txn(9'h000, 32'h0080_0000, 11'h005, 32'h0000_0005);
        $display("t_ctrl done");
    endtask

    task automatic t_irq;
        apb(1'b0, 8'h14, 32'h0);
        `CHK(se, 1'b1)
        apb(1'b1, ADDR_ICLR, 32'h0000_001F);
        apb(1'b1, ADDR_IEN, 32'h0);
        txn(9'h040, 32'h0080_0000, 11'h005, 32'h0088_0005);
        apb(1'b0, ADDR_STS, 32'h0);
        `CHK(rd, 32'h0000_0008)
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_IEN, 32'h0000_0008);
        apb(1'b0, ADDR_LAST, 32'h0);
        `CHK(rd, 32'h0088_0005)
        `CHK(irq, 1'b1)
        apb(1'b1, ADDR_ICLR, 32'h0000_0008);
        apb(1'b0, ADDR_STS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        `CHK(irq, 1'b0)
        $display("t_irq done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        go = 1'b0;
        oc = 9'h000;
        td = 32'h0080_0000;
        act = 11'h000;
        mx = 11'h007;
        err_count = 0;
        n_tests = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_stall();
        t_nak();
        t_buffer();
        t_timeout();
        t_ctrl();
        t_irq();
        conclude();
    end
endmodule
`default_nettype wire

//--- utw_endpoint_model.sv
// Far-side endpoint model driving one transaction outcome per request
`timescale 1ns/100ps
`default_nettype none
module utw_endpoint_model (
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [8:0] oc,
    output var  logic       done,
    output var  logic [8:0] lines
);
    initial begin
        done  = 1'b0;
        lines = 9'h000;
    end
    // Outcome lines are undriven outside the done cycle: toggle, not hold
    always @(posedge pclk) begin
        done  <= go;
        lines <= go ? oc : ~lines;
    end
endmodule
`default_nettype wire

//--- utw_pkg.sv
// Constants and types for the descriptor status write-back block
package utw_pkg;
    // APB register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STS  = 8'h04;
    localparam logic [7:0] ADDR_IEN  = 8'h08;
    localparam logic [7:0] ADDR_ICLR = 8'h0C;
    localparam logic [7:0] ADDR_LAST = 8'h10;
    // Descriptor control/status word fields
    localparam int BIT_ISO    = 25;
    localparam int BIT_ACTIVE = 23;
    localparam int BIT_STALL  = 22;
    localparam int BIT_BUFE   = 21;
    localparam int BIT_BABBLE = 20;
    localparam int BIT_NAK    = 19;
    localparam int BIT_CRCTO  = 18;
    localparam int LEN_MSB    = 10;
    localparam int LEN_W      = LEN_MSB + 1;
    localparam logic [LEN_W-1:0] LEN_ONE = 11'h001;
    // Interrupt status bit positions
    localparam int EV_STALL  = 0;
    localparam int EV_BUFE   = 1;
    localparam int EV_BABBLE = 2;
    localparam int EV_NAK    = 3;
    localparam int EV_CRCTO  = 4;
    localparam int EV_W      = 5;
    // Reset values and the control enable bit position
    localparam logic             CTRL_EN_RST = 1'b1;
    localparam logic [EV_W-1:0]  EV_ZERO     = 5'h00;
    localparam logic [31:0]      WORD_ZERO   = 32'h0000_0000;
    localparam int               CTRL_EN_BIT = 0;

    typedef enum logic [1:0] {
        FSM_IDLE = 2'b01,
        FSM_WB   = 2'b10
    } utw_fsm_t;

    typedef struct packed {
        utw_fsm_t        st;
        logic            ctrl_en;
        logic [EV_W-1:0] sts;
        logic [EV_W-1:0] ien;
        logic [31:0]     last;
        logic [31:0]     wb_data;
        logic            wb_valid;
        logic            frame_abort;
        logic            crc_corrupt;
        logic            force_timeout;
        logic            irq;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } utw_state_t;
endpackage
